// ---- core/twt_sleep_wake_scheduler.sv ----
// design: station-side target wake time scheduler with host sleep/wake handshake
`default_nettype none
module twt_sleep_wake_scheduler (
  input  wire logic                          ref_clk,
  input  wire logic                          nrst,
  twt_if.device                              link,
  input  wire logic                          session_enable,
  input  wire logic [twt_pkg::DUR_W-1:0]     wake_duration,
  input  wire logic [twt_pkg::UNIT_W-1:0]    wake_duration_unit,
  input  wire logic [twt_pkg::MANT_W-1:0]    wake_int_mantissa,
  input  wire logic [twt_pkg::EXP_W-1:0]     wake_int_exp,
  input  wire logic                          silent_wake_select,
  input  wire logic                          setup_accepted,
  input  wire logic                          beacon_aid_set,
  input  wire logic                          ap_frame_valid,
  input  wire logic [twt_pkg::DATA_W-1:0]    ap_frame_data,
  input  wire logic                          ap_more_data,
  output logic                               assoc_req,
  output logic                               he_requester_support,
  output logic                               null_frame_tx,
  output logic                               null_pwr_mgt,
  output logic                               ps_poll_tx,
  output logic                               trigger_tx,
  output logic                               fetch_active,
  output logic                               beacon_rx_en,
  output logic                               awake,
  output logic                               host_tx_ready,
  output logic [twt_pkg::TIME_W-1:0]         next_wake_time,
  output logic [twt_pkg::TIME_W-1:0]         sleep_duration
);
  import twt_pkg::*;

  // ****************************************
  // host request synchroniser
  // ****************************************
  logic req_meta_q, req_sync_q;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      req_meta_q <= 1'b0;
      req_sync_q <= 1'b0;
    end else begin
      req_meta_q <= link.host_wake_request_in;
      req_sync_q <= req_meta_q;
    end
  end

  // ****************************************
  // schedule arithmetic
  // ****************************************
  logic [TIME_W-1:0] sp_cyc, int_cyc;
  always_comb begin
    sp_cyc  = sp_len(wake_duration, wake_duration_unit);
    int_cyc = wake_int(wake_int_mantissa, wake_int_exp);
  end

  // ****************************************
  // scheduler state
  // ****************************************
  sched_state_type   st_q, st_d;
  logic [TIME_W-1:0] now_q, now_d;
  logic [TIME_W-1:0] twt_q, twt_d;
  logic [TIME_W-1:0] sp_end_q, sp_end_d;
  logic [TIME_W-1:0] slp_q, slp_d;
  logic [TIME_W-1:0] bcn_q, bcn_d;
  logic              fetch_q, fetch_d;
  logic              ind_q, ind_d;
  logic              rxv_q, rxv_d;
  logic [DATA_W-1:0] rxd_q, rxd_d;

  always_comb begin
    st_d     = st_q;
    now_d    = now_q + TIME_W'(1);
    twt_d    = twt_q;
    sp_end_d = sp_end_q;
    slp_d    = slp_q;
    bcn_d    = bcn_q;
    fetch_d  = fetch_q;
    ind_d    = ind_q;
    rxv_d    = 1'b0;
    rxd_d    = rxd_q;
    case (st_q)
      ST_IDLE: begin
        if (session_enable) begin
          st_d = ST_ASSOC;
        end
      end
      ST_ASSOC: begin
        if (setup_accepted) begin
          st_d = ST_NULL_TX;
        end
      end
      ST_NULL_TX: begin
        st_d  = ST_SLEEP;
        twt_d = now_q + int_cyc;
        slp_d = int_cyc - sp_cyc;
      end
      ST_SLEEP: begin
        if (now_q + TIME_W'(BEACON_LEAD_CYC) >= twt_q) begin
          st_d  = ST_BEACON;
          bcn_d = TIME_W'(BEACON_LISTEN_CYC);
        end
      end
      ST_BEACON: begin
        bcn_d = bcn_q - TIME_W'(1);
        if (beacon_aid_set) begin
          fetch_d = 1'b1;
        end
        if (bcn_q == '0 || now_q >= twt_q) begin
          st_d = ST_WAIT_SP;
        end
      end
      ST_WAIT_SP: begin
        if (now_q >= twt_q) begin
          st_d     = ST_SERVE;
          ind_d    = 1'b1;
          sp_end_d = twt_q + sp_cyc;
          twt_d    = twt_q + int_cyc;
          slp_d    = int_cyc - sp_cyc;
        end
      end
      ST_SERVE: begin
        if (fetch_q && ap_frame_valid) begin
          rxv_d = 1'b1;
          rxd_d = ap_frame_data;
          if (!ap_more_data) begin
            fetch_d = 1'b0;
          end
        end
        // status rose one cycle after the start, so it falls one cycle after the end: sp_cyc high cycles
        if (now_q >= sp_end_q) begin
          st_d    = ST_SLEEP;
          fetch_d = 1'b0;
          ind_d   = 1'b0;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    if (!session_enable) begin
      st_d    = ST_IDLE;
      fetch_d = 1'b0;
      ind_d   = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_q     <= ST_IDLE;
      now_q    <= '0;
      twt_q    <= '0;
      sp_end_q <= '0;
      slp_q    <= '0;
      bcn_q    <= '0;
      fetch_q  <= 1'b0;
      ind_q    <= 1'b0;
      rxv_q    <= 1'b0;
      rxd_q    <= '0;
    end else begin
      st_q     <= st_d;
      now_q    <= now_d;
      twt_q    <= twt_d;
      sp_end_q <= sp_end_d;
      slp_q    <= slp_d;
      bcn_q    <= bcn_d;
      fetch_q  <= fetch_d;
      ind_q    <= ind_d;
      rxv_q    <= rxv_d;
      rxd_q    <= rxd_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // indication level follows the service period; the host reads its edge
  assign link.wake_status_out_primary   = ind_q;
  assign link.wake_status_out_alternate = ind_q;
  assign link.rx_valid                  = rxv_q;
  assign link.rx_data                   = rxd_q;
  assign assoc_req            = (st_q == ST_ASSOC);
  assign he_requester_support = (st_q == ST_ASSOC);
  assign null_frame_tx        = (st_q == ST_NULL_TX);
  assign null_pwr_mgt         = 1'b1;
  // unannounced, non-triggered: never poll or trigger, whatever the select
  assign ps_poll_tx           = 1'b0 & ~silent_wake_select;
  assign trigger_tx           = 1'b0;
  assign fetch_active         = fetch_q & (st_q == ST_SERVE);
  assign beacon_rx_en         = (st_q == ST_BEACON);
  assign awake                = (st_q == ST_SERVE);
  // host words accepted only while serving and the host still asks
  assign host_tx_ready        = (st_q == ST_SERVE) & req_sync_q;
  assign next_wake_time       = twt_q;
  assign sleep_duration       = slp_q;
endmodule : twt_sleep_wake_scheduler
`default_nettype wire

// ---- pkg/twt_pkg.sv ----
// package: timing, field widths and states for the wake-time scheduler and its host end
// How it works
// - service period is duration count times unit
// - interval is mantissa shifted by exponent
// - sleep is interval minus service period
// - next wake adds fixed interval, no renegotiation
// - no poll or trigger frames announce wake
// - no trigger frames used inside service period
// - requester support bit set during association
// - after accept send null frame, sleep
// - wake early for beacon, then sleep again
// - flagged traffic: fetch while more data set
// - nothing left: stay awake until period ends
// - period end forces sleep, defer pending transfers
// - received frames go to host unhandshaked
// - status high on wake, low at sleep
// - host raises request, waits for wake indication
// - wake indication only at next service period
// - host transfers only inside service period
// - host drops request after its transfer
// - leftover host work waits for next period
// - session enable written zero tears session down
`default_nettype none
package twt_pkg;
  localparam int unsigned DUR_W      = 8;
  localparam int unsigned UNIT_W     = 16;
  localparam int unsigned MANT_W     = 16;
  localparam int unsigned EXP_W      = 5;
  localparam int unsigned TIME_W     = 48;
  localparam int unsigned DATA_W     = 8;
  // beacon lead time ahead of the service period
  localparam int unsigned BEACON_LEAD_NS  = 1000;
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned BEACON_LEAD_CYC = (BEACON_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // length of the beacon listen window
  localparam int unsigned BEACON_LISTEN_NS  = 500;
  localparam int unsigned BEACON_LISTEN_CYC = BEACON_LISTEN_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ASSOC, ST_NULL_TX, ST_SLEEP, ST_BEACON, ST_WAIT_SP, ST_SERVE
  } sched_state_type;

  typedef enum logic [1:0] {
    H_IDLE, H_WAIT, H_SEND, H_DONE
  } host_state_type;

  function automatic logic [TIME_W-1:0] sp_len(input logic [DUR_W-1:0] d, input logic [UNIT_W-1:0] u);
    sp_len = TIME_W'(d) * TIME_W'(u);
  endfunction

  function automatic logic [TIME_W-1:0] wake_int(input logic [MANT_W-1:0] m, input logic [EXP_W-1:0] e);
    wake_int = TIME_W'(m) << e;
  endfunction
endpackage : twt_pkg
`default_nettype wire

// ---- pkg/twt_if.sv ----
// interface: wake handshake pins and data path between scheduler and host
`default_nettype none
interface twt_if;
  logic                      host_wake_request_in;
  logic                      wake_status_out_primary;
  logic                      wake_status_out_alternate;
  logic                      rx_valid;
  logic [twt_pkg::DATA_W-1:0] rx_data;
  logic                      tx_valid;
  logic [twt_pkg::DATA_W-1:0] tx_data;

  modport device (
    input  host_wake_request_in,
    output wake_status_out_primary,
    output wake_status_out_alternate,
    output rx_valid,
    output rx_data,
    input  tx_valid,
    input  tx_data
  );
  modport host (
    output host_wake_request_in,
    input  wake_status_out_primary,
    input  wake_status_out_alternate,
    input  rx_valid,
    input  rx_data,
    output tx_valid,
    output tx_data
  );
endinterface : twt_if
`default_nettype wire

// ---- core/twt_host_end.sv ----
// design: host-side wake handshake end
`default_nettype none
module twt_host_end (
  input  wire logic                       ref_clk,
  input  wire logic                       nrst,
  twt_if.host                             link,
  input  wire logic                       send_req,
  input  wire logic [twt_pkg::DATA_W-1:0] send_data,
  output logic                            send_ack,
  output logic                            host_busy,
  output logic                            rx_valid,
  output logic [twt_pkg::DATA_W-1:0]      rx_data
);
  import twt_pkg::*;

  // ****************************************
  // status synchroniser
  // ****************************************
  logic st_meta_q, st_sync_q, st_prev_q;
  logic rv_meta_q, rv_sync_q;
  logic [DATA_W-1:0] rd_meta_q, rd_sync_q;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_meta_q <= 1'b0;
      st_sync_q <= 1'b0;
      st_prev_q <= 1'b0;
      rv_meta_q <= 1'b0;
      rv_sync_q <= 1'b0;
      rd_meta_q <= '0;
      rd_sync_q <= '0;
    end else begin
      st_meta_q <= link.wake_status_out_primary;
      st_sync_q <= st_meta_q;
      st_prev_q <= st_sync_q;
      rv_meta_q <= link.rx_valid;
      rv_sync_q <= rv_meta_q;
      rd_meta_q <= link.rx_data;
      rd_sync_q <= rd_meta_q;
    end
  end

  // ****************************************
  // handshake state
  // ****************************************
  host_state_type    hs_q, hs_d;
  logic              req_q, req_d;
  logic              txv_q, txv_d;
  logic [DATA_W-1:0] txd_q, txd_d;
  logic              ack_q, ack_d;

  always_comb begin
    hs_d  = hs_q;
    req_d = req_q;
    txv_d = 1'b0;
    txd_d = txd_q;
    ack_d = 1'b0;
    case (hs_q)
      H_IDLE: begin
        if (send_req) begin
          hs_d  = H_WAIT;
          req_d = 1'b1;
        end
      end
      H_WAIT: begin
        if (st_sync_q && !st_prev_q) begin
          hs_d = H_SEND;
        end
      end
      H_SEND: begin
        if (!st_sync_q) begin
          hs_d = H_WAIT;
        end else if (send_req) begin
          txv_d = 1'b1;
          txd_d = send_data;
          ack_d = 1'b1;
          hs_d  = H_DONE;
        end
      end
      H_DONE: begin
        req_d = 1'b0;
        hs_d  = H_IDLE;
      end
      default: begin
        hs_d = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      hs_q  <= H_IDLE;
      req_q <= 1'b0;
      txv_q <= 1'b0;
      txd_q <= '0;
      ack_q <= 1'b0;
    end else begin
      hs_q  <= hs_d;
      req_q <= req_d;
      txv_q <= txv_d;
      txd_q <= txd_d;
      ack_q <= ack_d;
    end
  end

  assign link.host_wake_request_in = req_q;
  assign link.tx_valid             = txv_q;
  assign link.tx_data              = txd_q;
  assign send_ack                  = ack_q;
  assign host_busy                 = (hs_q != H_IDLE);
  assign rx_valid                  = rv_sync_q;
  assign rx_data                   = rd_sync_q;
endmodule : twt_host_end
`default_nettype wire

// ---- verification/twt_sleep_wake_scheduler_asserts.sv ----
// checker: wake handshake timing seen on the scheduler/host link
`default_nettype none
module twt_sleep_wake_scheduler_asserts #(
  parameter int unsigned SP_CYC  = 12,
  parameter int unsigned INT_CYC = 40
) (
  input wire logic                       ref_clk,
  input wire logic                       nrst,
  input wire logic                       host_wake_request_in,
  input wire logic                       wake_status_out_primary,
  input wire logic                       wake_status_out_alternate,
  input wire logic                       rx_valid,
  input wire logic [twt_pkg::DATA_W-1:0] rx_data,
  input wire logic                       tx_valid,
  input wire logic [twt_pkg::DATA_W-1:0] tx_data
);
  timeunit 1ns;
  timeprecision 1ns;
  import twt_pkg::*;
  logic [31:0] per_q;
  logic [31:0] hi_q;
  logic [31:0] lo_q;
  logic        seen_q;
  logic        prev_q;
  wire logic   st = wake_status_out_primary;
  // the first rise after reset has no period behind it, hence seen_q
  always_ff @(posedge ref_clk) begin
    prev_q <= nrst & st;
    seen_q <= nrst & (seen_q | (st & ~prev_q));
    per_q  <= (st & ~prev_q) ? 32'h1 : per_q + 32'h1;
    hi_q   <= st ? hi_q + 32'h1 : 32'h0;
    lo_q   <= st ? 32'h0 : lo_q + 32'h1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence release_s;
    ##[1:2] !host_wake_request_in;
  endsequence
  chk_status_pair: assert property (st == wake_status_out_alternate)
    else $error("status outputs differ");
  chk_sp_len: assert property ($fell(st) |-> hi_q == SP_CYC)
    else $error("service period length wrong");
  chk_sleep_len: assert property ($rose(st) && seen_q |-> lo_q == INT_CYC - SP_CYC)
    else $error("sleep length wrong");
  chk_wake_period: assert property ($rose(st) && seen_q |-> per_q == INT_CYC)
    else $error("wake interval wrong");
  chk_tx_in_sp: assert property (tx_valid |-> st || $past(st, 3))
    else $error("host byte outside service period");
  chk_tx_single: assert property (tx_valid |=> !tx_valid)
    else $error("host byte longer than one cycle");
  chk_req_drop: assert property (tx_valid |-> release_s)
    else $error("wake request not released");
  chk_req_hold: assert property ($fell(host_wake_request_in) |-> $past(tx_valid) || $past(tx_valid, 2))
    else $error("wake request dropped before sending");
  chk_rx_in_sp: assert property (rx_valid |-> st || $past(st))
    else $error("frame to host outside service period");
  chk_rx_data_held: assert property ($changed(rx_data) |-> rx_valid)
    else $error("frame data changed without valid");
  chk_tx_data_held: assert property ($changed(tx_data) |-> tx_valid)
    else $error("host data changed without valid");
endmodule // twt_sleep_wake_scheduler_asserts
`default_nettype wire

// ---- verification/twt_sleep_wake_scheduler_tb.sv ----
// testbench: scheduler and host end joined over the wake handshake link
`default_nettype none
module twt_sleep_wake_scheduler_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import twt_pkg::*;
  logic              ref_clk, nrst, session_enable, setup_accepted, beacon_aid_set, send_req, send_ack;
  logic              ap_frame_valid, ap_more_data, assoc_req, he_requester_support, null_frame_tx, null_pwr_mgt;
  logic              ps_poll_tx, trigger_tx, fetch_active, beacon_rx_en, awake, poll_seen;
  logic [DATA_W-1:0] ap_frame_data, send_data, h_rx_data;
  logic [TIME_W-1:0] next_wake_time, sleep_duration, nw0;
  logic [DUR_W-1:0]  wake_duration;
  logic [UNIT_W-1:0] wake_duration_unit;
  logic [MANT_W-1:0] wake_int_mantissa;
  logic [EXP_W-1:0]  wake_int_exp;
  logic              host_tx_ready, host_busy, h_rx_valid;
  int                err_count, comparisons, n, h_rx_cnt;
  twt_if link ();
  wire logic [4:0]   watch = {assoc_req, send_ack, beacon_rx_en, null_frame_tx, link.wake_status_out_primary};
  // ************
  // ** instances
  // ************
  // sp = 4 * 3 = 12 cycles, interval = 5 << 3 = 40 cycles
  twt_sleep_wake_scheduler twt_sleep_wake_scheduler_inst (.ref_clk, .nrst, .link(link.device), .session_enable,
    .wake_duration, .wake_duration_unit, .wake_int_mantissa, .wake_int_exp,
    .silent_wake_select(1'b1), .setup_accepted, .beacon_aid_set, .ap_frame_valid, .ap_frame_data, .ap_more_data,
    .assoc_req, .he_requester_support, .null_frame_tx, .null_pwr_mgt, .ps_poll_tx, .trigger_tx, .fetch_active,
    .beacon_rx_en, .awake, .host_tx_ready, .next_wake_time, .sleep_duration);
  twt_host_end twt_host_end_inst (.ref_clk, .nrst, .link(link.host), .send_req, .send_data, .send_ack,
    .host_busy, .rx_valid(h_rx_valid), .rx_data(h_rx_data));
  twt_sleep_wake_scheduler_asserts #(.SP_CYC(12), .INT_CYC(40)) twt_sleep_wake_scheduler_asserts_inst (
    .ref_clk, .nrst, .host_wake_request_in(link.host_wake_request_in),
    .wake_status_out_primary(link.wake_status_out_primary),
    .wake_status_out_alternate(link.wake_status_out_alternate), .rx_valid(link.rx_valid),
    .rx_data(link.rx_data), .tx_valid(link.tx_valid), .tx_data(link.tx_data));
  // ************
  // ** helpers
  // ************
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) if (nrst === 1'b1) poll_seen = poll_seen | ps_poll_tx | trigger_tx;
  always @(negedge ref_clk) if (nrst === 1'b1 && h_rx_valid === 1'b1) h_rx_cnt++;
  task automatic chk(input string what, input logic [TIME_W-1:0] exp, input logic [TIME_W-1:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // bounded wait, sampled at the falling edge so one-cycle pulses are seen
  task automatic wait_bit(input int b, input logic lvl, input int lim);
    int k = 0;
    while (watch[b] !== lvl && k < lim) begin
      @(negedge ref_clk);
      k++;
    end
    if (watch[b] !== lvl) begin
      err_count++;
      $display("BAD wait bit %0d expected %0b seen %0b", b, lvl, watch[b]);
      conclude();
    end
  endtask
  task automatic frame(input logic [DATA_W-1:0] d, input logic more, input logic look);
    @(negedge ref_clk);
    ap_frame_valid = 1'b1;
    ap_frame_data = d;
    ap_more_data = more;
    @(negedge ref_clk);
    ap_frame_valid = 1'b0;
    if (look) begin
      chk("rx_valid", 1, link.rx_valid);
      chk("rx_data", d, link.rx_data);
    end
  endtask
  // ************
  // ** sequence
  // ************
  initial begin
    {nrst, session_enable, setup_accepted, beacon_aid_set, ap_frame_valid, ap_more_data, send_req} = '0;
    {ap_frame_data, send_data, poll_seen, err_count, comparisons, h_rx_cnt} = '0;
    wake_duration      = 8'h04;
    wake_duration_unit = 16'h0003;
    wake_int_mantissa  = 16'h0005;
    wake_int_exp       = 5'h03;
    repeat (6) @(negedge ref_clk);
    nrst = 1'b1;
    @(negedge ref_clk);
    session_enable = 1'b1;
    wait_bit(4, 1'b1, 5);
    chk("he_requester_support", 1, he_requester_support);
    setup_accepted = 1'b1;
    wait_bit(1, 1'b1, 5);
    setup_accepted = 1'b0;
    chk("null_pwr_mgt", 1, null_pwr_mgt);
    @(negedge ref_clk);
    chk("awake", 0, awake);
    $display("test setup done");
    beacon_aid_set = 1'b1;
    wait_bit(2, 1'b1, 60);
    chk("awake at beacon", 0, awake);
    chk("status at beacon", 0, link.wake_status_out_primary);
    wait_bit(0, 1'b1, 20);
    chk("beacon_rx_en", 0, beacon_rx_en);
    frame(8'h11, 1'b1, 1'b1);
    chk("fetch_active", 1, fetch_active);
    frame(8'h22, 1'b1, 1'b1);
    frame(8'h33, 1'b0, 1'b1);
    @(negedge ref_clk);
    chk("fetch_active", 0, fetch_active);
    chk("awake", 1, awake);
    wait_bit(0, 1'b0, 20);
    chk("awake", 0, awake);
    chk("host rx_data", 8'h33, h_rx_data);
    chk("host rx_valid count", 3, h_rx_cnt);
    chk("sleep_duration", 28, sleep_duration);
    nw0 = next_wake_time;
    beacon_aid_set = 1'b0;
    $display("test fetch done");
    send_req = 1'b1;
    send_data = 8'hA5;
    repeat (2) @(negedge ref_clk);
    chk("wake request", 1, link.host_wake_request_in);
    chk("host_busy", 1, host_busy);
    chk("status", 0, link.wake_status_out_primary);
    wait_bit(3, 1'b1, 60);
    chk("tx_valid", 1, link.tx_valid);
    chk("tx_data", 8'hA5, link.tx_data);
    chk("awake", 1, awake);
    chk("host_tx_ready", 1, host_tx_ready);
    send_req = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("wake request", 0, link.host_wake_request_in);
    wait_bit(0, 1'b0, 20);
    chk("host_tx_ready", 0, host_tx_ready);
    chk("host_busy", 0, host_busy);
    chk("next_wake_time", nw0 + 48'h28, next_wake_time);
    $display("test host done");
    beacon_aid_set = 1'b1;
    wait_bit(0, 1'b1, 60);
    n = 0;
    // keep offering data past the end; the period must still close
    while (link.wake_status_out_primary === 1'b1 && n < 20) begin
      frame(8'h44, 1'b1, 1'b0);
      n++;
    end
    chk("status", 0, link.wake_status_out_primary);
    chk("fetch_active", 0, fetch_active);
    $display("test overrun done");
    session_enable = 1'b0;
    repeat (60) begin
      @(negedge ref_clk);
      chk("status torn down", 0, link.wake_status_out_primary);
    end
    chk("poll or trigger", 0, poll_seen);
    $display("test teardown done");
    conclude();
  end
endmodule // twt_sleep_wake_scheduler_tb
`default_nettype wire
